// *** bsx_pkg.sv ***
// Package with constants, opcode patterns and states of the branch, skip and shift execute slice.
package bsx_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int          PC_W        = 22;
  localparam logic [21:0] PC_RESET    = 22'h000000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET    = 16'h00ff;
  localparam logic [3:0]  Z_LO_IDX    = 4'he;
  localparam logic [3:0]  Z_HI_IDX    = 4'hf;
  localparam logic [7:0]  ALL_ONES    = 8'hff;
  localparam logic [7:0]  SIGN_MIN    = 8'h80;

  // ==========================================================================
  // Status flag bit positions
  // ==========================================================================
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam logic [2:0] SEL_S = 3'h4;

  // ==========================================================================
  // Register map, byte addresses
  // ==========================================================================
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC     = 8'h08;
  localparam logic [7:0] OFF_FLAGS  = 8'h0c;
  localparam logic [7:0] OFF_SP     = 8'h10;
  localparam logic [1:0] GPR_PAGE   = 2'h1;
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_CLR_UNK = 1;

  // ==========================================================================
  // Opcode masks and patterns
  // ==========================================================================
  localparam logic [15:0] M_TWO   = 16'hfc00;
  localparam logic [15:0] P_AND   = 16'h2000;
  localparam logic [15:0] P_EOR   = 16'h2400;
  localparam logic [15:0] P_ADD   = 16'h0c00;
  localparam logic [15:0] P_ADC   = 16'h1c00;
  localparam logic [15:0] P_COMPARE_EQUAL_SKIP  = 16'h1000;
  localparam logic [15:0] M_SER   = 16'hff0f;
  localparam logic [15:0] P_SER   = 16'hef0f;
  localparam logic [15:0] M_ONE   = 16'hfe0f;
  localparam logic [15:0] P_DEC   = 16'h940a;
  localparam logic [15:0] P_LSR   = 16'h9406;
  localparam logic [15:0] P_ROR   = 16'h9407;
  localparam logic [15:0] M_ALL   = 16'hffff;
  localparam logic [15:0] P_POINTER_JUMP  = 16'h9409;
  localparam logic [15:0] P_POINTER_CALL = 16'h9509;
  localparam logic [15:0] M_REL   = 16'hf000;
  localparam logic [15:0] P_OFFSET_JUMP  = 16'hc000;
  localparam logic [15:0] P_OFFSET_CALL = 16'hd000;
  localparam logic [15:0] M_SBR   = 16'hfe08;
  localparam logic [15:0] P_REG_BIT_CLEAR_SKIP  = 16'hfc00;
  localparam logic [15:0] P_REG_BIT_SET_SKIP  = 16'hfe00;
  localparam logic [15:0] M_SBI   = 16'hff00;
  localparam logic [15:0] P_IO_BIT_CLEAR_SKIP  = 16'h9900;
  localparam logic [15:0] P_IO_BIT_SET_SKIP  = 16'h9b00;
  localparam logic [15:0] M_BR    = 16'hfc00;
  localparam logic [15:0] P_BRANCH_FLAG_SET  = 16'hf000;
  localparam logic [15:0] P_BRANCH_FLAG_CLEAR  = 16'hf400;
  localparam logic [15:0] M_LONG  = 16'hfe0c;
  localparam logic [15:0] P_LONG  = 16'h940c;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_HALT, ST_EXEC, ST_BUBBLE, ST_PUSH_LO, ST_PUSH_HI, ST_SKIP, ST_SKIP2
  } bsx_state_e;

  // Compares an opcode against a mask and pattern.
  function automatic logic op_is(input logic [15:0] op, input logic [15:0] m,
                                 input logic [15:0] p);
    op_is = ((op & m) == p);
  endfunction : op_is

endpackage : bsx_pkg

// *** bsx_core.sv ***
// Execute slice for test, clear, shifts, rotates, skips, jumps, calls and flag branches.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
//
// Summary of operation
// - Test ANDs register with itself, sets Z N V S, one cycle.
// - Pointer jump loads PC from Z, upper bits zero, two cycles, flags kept.
// - Pointer call jumps like pointer jump and pushes return address, three cycles.
// - Compare-equal skip jumps over next instruction when registers match, flags kept.
// - Register bit skips test a register bit, skipping on clear or set.
// - I/O bit skips test an I/O register bit, skipping on clear or set.
// - Flag branches add offset plus one when selected flag matches, 1/2 cycles.
// - Carry branches go on carry clear for same-higher and set for lower.
// - Signed compare branches test negative XOR overflow for zero or one.
// - Half-carry branches go when half carry is set or clear.
// - T-bit branches go when the T bit is set or clear.
// - Overflow branches go when overflow is set or clear.
// - Interrupt-state branches go when global interrupt enable is one or zero.
// - Rotate left takes carry in at bit 0, bit 7 out, one cycle.
// - Rotate right takes carry in at bit 7, bit 0 out, one cycle.
module bsx_core
  import bsx_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Avalon-MM register slave.
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Program memory, combinational read.
  output logic [PC_W-1:0]        prog_addr,
  input  wire logic [15:0]       prog_data,
  // Snapshot of the 32 bit-addressable I/O registers.
  input  wire logic [255:0]      io_regs,
  // Stack write port.
  output logic                   stack_we,
  output logic [15:0]            stack_addr,
  output logic [7:0]             stack_wdata,
  // Execution progress.
  output logic                   instr_done
);

  // ==========================================================================
  // State
  // ==========================================================================
  bsx_state_e         state_r, state_nxt;
  logic [PC_W-1:0]    pc_r, pc_nxt;
  logic [7:0]         flags_r, flags_nxt;
  logic [15:0]        sp_r;
  logic [7:0]         gpr [16];
  logic [PC_W-1:0]    ret_r;
  logic               run_r, unk_r;
  logic [1:0]         cyc_r, last_cyc_r;
  logic               gw_en;
  logic [3:0]         gw_idx;
  logic [7:0]         gw_val;
  logic               push_go, unk_set, done_nxt;
  logic [7:0]         rd_v, rr_v, res;
  logic               is_tst, is_pointer_jump, is_pointer_call, is_compare_equal_skip, is_rol, is_br, br_go;
  logic               skip_go, fbit;
  logic               bus_req, bus_take, halted;
  logic [31:0]        rdata_nxt;

  // Adds a signed offset plus one to the program counter.
  function automatic logic [PC_W-1:0] rel_pc(input logic [PC_W-1:0] pc,
                                            input logic [PC_W-1:0] k);
    rel_pc = pc + k + PC_W'(1);
  endfunction : rel_pc

  // Merges byte lanes of a write into an old word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lane_merge

  assign halted   = (state_r == ST_HALT);
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;

  // ==========================================================================
  // Decode and execute
  // ==========================================================================
  // Works out next PC, flags, register write and sequencer state.
  always_comb begin
    rd_v      = gpr[prog_data[7:4]];
    rr_v      = gpr[prog_data[3:0]];
    res       = 8'h00;
    state_nxt = state_r;
    pc_nxt    = pc_r;
    flags_nxt = flags_r;
    gw_en     = 1'b0;
    gw_idx    = prog_data[7:4];
    gw_val    = 8'h00;
    push_go   = 1'b0;
    unk_set   = 1'b0;
    done_nxt  = 1'b0;
    skip_go   = 1'b0;
    is_tst    = op_is(prog_data, M_TWO, P_AND) && (prog_data[9] == prog_data[8]) &&
                (prog_data[3:0] == prog_data[7:4]);
    is_pointer_jump   = op_is(prog_data, M_ALL, P_POINTER_JUMP);
    is_pointer_call  = op_is(prog_data, M_ALL, P_POINTER_CALL);
    is_compare_equal_skip   = op_is(prog_data, M_TWO, P_COMPARE_EQUAL_SKIP);
    is_rol    = op_is(prog_data, M_TWO, P_ADC) && (prog_data[3:0] == prog_data[7:4]);
    is_br     = op_is(prog_data, M_BR, P_BRANCH_FLAG_SET) || op_is(prog_data, M_BR, P_BRANCH_FLAG_CLEAR);
    fbit      = (prog_data[2:0] == SEL_S) ? (flags_r[FL_N] ^ flags_r[FL_V])
                                          : flags_r[prog_data[2:0]];
    br_go     = prog_data[10] ? ~fbit : fbit;
    case (state_r)
      ST_HALT: begin
        if (run_r) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        pc_nxt    = pc_r + PC_W'(1);
        state_nxt = run_r ? ST_EXEC : ST_HALT;
        done_nxt  = 1'b1;
        if (is_tst) begin
          res = rd_v & rd_v;
          flags_nxt[FL_Z] = (res == 8'h00);
          flags_nxt[FL_N] = res[7];
          flags_nxt[FL_V] = 1'b0;
          flags_nxt[FL_S] = res[7];
        end else if (op_is(prog_data, M_TWO, P_EOR) && (prog_data[3:0] == prog_data[7:4])) begin
          res = rd_v ^ rd_v;
          gw_en = 1'b1;
          gw_val = res;
          flags_nxt[FL_Z] = 1'b1;
          flags_nxt[FL_N] = 1'b0;
          flags_nxt[FL_V] = 1'b0;
          flags_nxt[FL_S] = 1'b0;
        end else if (op_is(prog_data, M_ONE, P_DEC)) begin
          res = rd_v - 8'h01;
          gw_en = 1'b1;
          gw_val = res;
          flags_nxt[FL_Z] = (res == 8'h00);
          flags_nxt[FL_N] = res[7];
          flags_nxt[FL_V] = (rd_v == SIGN_MIN);
          flags_nxt[FL_S] = res[7] ^ (rd_v == SIGN_MIN);
        end else if (op_is(prog_data, M_SER, P_SER)) begin
          gw_en = 1'b1;
          gw_val = ALL_ONES;
        end else if (is_rol ||
                     (op_is(prog_data, M_TWO, P_ADD) && (prog_data[3:0] == prog_data[7:4]))) begin
          res = {rd_v[6:0], is_rol & flags_r[FL_C]};
          gw_en = 1'b1;
          gw_val = res;
          flags_nxt[FL_Z] = (res == 8'h00);
          flags_nxt[FL_C] = rd_v[7];
          flags_nxt[FL_N] = res[7];
          flags_nxt[FL_V] = res[7] ^ rd_v[7];
          flags_nxt[FL_H] = rd_v[3];
        end else if (op_is(prog_data, M_ONE, P_LSR) || op_is(prog_data, M_ONE, P_ROR)) begin
          res = {prog_data[0] & flags_r[FL_C], rd_v[7:1]};
          gw_en = 1'b1;
          gw_val = res;
          flags_nxt[FL_Z] = (res == 8'h00);
          flags_nxt[FL_C] = rd_v[0];
          flags_nxt[FL_N] = res[7];
          flags_nxt[FL_V] = res[7] ^ rd_v[0];
        end else if (is_pointer_jump || is_pointer_call) begin
          pc_nxt = {6'h00, gpr[Z_HI_IDX], gpr[Z_LO_IDX]};
          state_nxt = is_pointer_call ? ST_PUSH_LO : ST_BUBBLE;
          push_go = is_pointer_call;
          done_nxt = 1'b0;
        end else if (op_is(prog_data, M_REL, P_OFFSET_JUMP) || op_is(prog_data, M_REL, P_OFFSET_CALL)) begin
          pc_nxt = rel_pc(pc_r, {{10{prog_data[11]}}, prog_data[11:0]});
          push_go = prog_data[12];
          state_nxt = prog_data[12] ? ST_PUSH_LO : ST_BUBBLE;
          done_nxt = 1'b0;
        end else if (is_br) begin
          if (br_go) begin
            pc_nxt = rel_pc(pc_r, {{15{prog_data[9]}}, prog_data[9:3]});
            state_nxt = ST_BUBBLE;
            done_nxt = 1'b0;
          end
        end else if (is_compare_equal_skip) begin
          skip_go = (rd_v == gpr[prog_data[3:0]]);
        end else if (op_is(prog_data, M_SBR, P_REG_BIT_CLEAR_SKIP) || op_is(prog_data, M_SBR, P_REG_BIT_SET_SKIP)) begin
          skip_go = (rd_v[prog_data[2:0]] == prog_data[9]);
        end else if (op_is(prog_data, M_SBI, P_IO_BIT_CLEAR_SKIP) || op_is(prog_data, M_SBI, P_IO_BIT_SET_SKIP)) begin
          skip_go = (io_regs[{prog_data[7:3], prog_data[2:0]}] == prog_data[9]);
        end else begin
          unk_set = 1'b1;
        end
        if (skip_go) begin
          state_nxt = ST_SKIP;
          done_nxt = 1'b0;
        end
      end
      ST_SKIP: begin
        pc_nxt = pc_r + PC_W'(1);
        state_nxt = op_is(prog_data, M_LONG, P_LONG) ? ST_SKIP2 : ST_BUBBLE;
        if (!op_is(prog_data, M_LONG, P_LONG)) begin
          state_nxt = run_r ? ST_EXEC : ST_HALT;
          done_nxt = 1'b1;
        end
      end
      ST_SKIP2: begin
        pc_nxt = pc_r + PC_W'(1);
        state_nxt = run_r ? ST_EXEC : ST_HALT;
        done_nxt = 1'b1;
      end
      ST_PUSH_LO: begin
        state_nxt = ST_PUSH_HI;
      end
      ST_PUSH_HI, ST_BUBBLE: begin
        state_nxt = run_r ? ST_EXEC : ST_HALT;
        done_nxt = 1'b1;
      end
      default: begin
        state_nxt = ST_HALT;
      end
    endcase
  end

  // ==========================================================================
  // Sequencer, program counter and flags
  // ==========================================================================
  // Steps the sequencer; PC and flags take bus writes only while halted.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r   <= ST_HALT;
      pc_r      <= PC_RESET;
      prog_addr <= PC_RESET;
      flags_r   <= FLAGS_RESET;
    end else begin
      state_r   <= state_nxt;
      pc_r      <= pc_nxt;
      prog_addr <= pc_nxt;
      flags_r   <= flags_nxt;
      if (halted && avs_write && bus_take && avs_address == OFF_PC) begin
        pc_r      <= PC_W'(lane_merge(32'(pc_r), avs_writedata, avs_byteenable));
        prog_addr <= PC_W'(lane_merge(32'(pc_r), avs_writedata, avs_byteenable));
      end
      if (halted && avs_write && bus_take && avs_address == OFF_FLAGS && avs_byteenable[0]) begin
        flags_r <= avs_writedata[7:0];
      end
    end
  end

  // Counts execute cycles and reports each finished instruction.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cyc_r      <= 2'h0;
      last_cyc_r <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= done_nxt;
      cyc_r      <= (done_nxt || halted) ? 2'h0 : cyc_r + 2'h1;
      if (done_nxt) begin
        last_cyc_r <= cyc_r + 2'h1;
      end
    end
  end

  // Writes the register file from execution, or from the bus while halted.
  always_ff @(posedge clk_sys) begin
    if (gw_en) begin
      gpr[gw_idx] <= gw_val;
    end else if (halted && avs_write && bus_take && avs_address[7:6] == GPR_PAGE &&
                 avs_byteenable[0]) begin
      gpr[avs_address[5:2]] <= avs_writedata[7:0];
    end
  end

  // ==========================================================================
  // Stack pushes
  // ==========================================================================
  // Pushes the return address low byte first, decrementing the stack pointer.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sp_r        <= SP_RESET;
      ret_r       <= PC_RESET;
      stack_we    <= 1'b0;
      stack_addr  <= 16'h0000;
      stack_wdata <= 8'h00;
    end else begin
      stack_we <= 1'b0;
      if (push_go) begin
        ret_r       <= pc_r + PC_W'(1);
        stack_we    <= 1'b1;
        stack_addr  <= sp_r;
        stack_wdata <= pc_r[7:0] + 8'h01;
        sp_r        <= sp_r - 16'h0001;
      end else if (state_r == ST_PUSH_LO) begin
        stack_we    <= 1'b1;
        stack_addr  <= sp_r;
        stack_wdata <= ret_r[15:8];
        sp_r        <= sp_r - 16'h0001;
      end else if (halted && avs_write && bus_take && avs_address == OFF_SP) begin
        sp_r <= 16'(lane_merge(32'(sp_r), avs_writedata, avs_byteenable));
      end
    end
  end

  // ==========================================================================
  // Avalon-MM slave
  // ==========================================================================
  // Selects read data; unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (avs_address[7:6] == GPR_PAGE) begin
      rdata_nxt = 32'(gpr[avs_address[5:2]]);
    end else begin
      case (avs_address)
        OFF_CTRL:   rdata_nxt = 32'(run_r);
        OFF_STATUS: rdata_nxt = {22'h0, last_cyc_r, 5'h0, ~halted, unk_r, run_r};
        OFF_PC:     rdata_nxt = 32'(pc_r);
        OFF_FLAGS:  rdata_nxt = 32'(flags_r);
        OFF_SP:     rdata_nxt = 32'(sp_r);
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Answers every request once, one cycle after it is seen.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  // Holds the run bit and the sticky unknown-opcode bit; a new set beats a clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_r <= 1'b0;
      unk_r <= 1'b0;
    end else begin
      if (avs_write && bus_take && avs_address == OFF_CTRL && avs_byteenable[0]) begin
        run_r <= avs_writedata[CTRL_RUN];
        if (avs_writedata[CTRL_CLR_UNK]) begin
          unk_r <= 1'b0;
        end
      end
      if (unk_set) begin
        unk_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_tst_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_tst) |=> instr_done && pc_r == $past(pc_r) + PC_W'(1))
    else $error("test did not finish in one cycle");
  a_pointer_jump_target: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_pointer_jump) |=> pc_r == {6'h00, $past(gpr[Z_HI_IDX]),
      $past(gpr[Z_LO_IDX])} && flags_r == $past(flags_r) ##1 instr_done)
    else $error("pointer jump target or timing wrong");
  a_pointer_call_push: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_pointer_call) |=> stack_we ##1 stack_we ##1 (instr_done && !stack_we))
    else $error("pointer call push sequence wrong");
  a_compare_equal_skip_keeps: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_compare_equal_skip) |=> flags_r == $past(flags_r) &&
      (state_r == ST_SKIP) == ($past(rd_v) == $past(rr_v)))
    else $error("compare skip decision or flags wrong");
  a_skip_length: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_SKIP && !op_is(prog_data, M_LONG, P_LONG)) |=> instr_done &&
      last_cyc_r == 2'h2)
    else $error("one-word skip did not take two cycles");
  a_branch_taken: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_br && br_go) |=> state_r == ST_BUBBLE && !instr_done
      ##1 instr_done && last_cyc_r == 2'h2)
    else $error("taken branch did not take two cycles");
  a_branch_idle: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_br && !br_go) |=> instr_done &&
      pc_r == $past(pc_r) + PC_W'(1))
    else $error("untaken branch misbehaved");
  a_rol_carry: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_EXEC && is_rol) |=> flags_r[FL_C] == $past(rd_v[7]) &&
      gpr[$past(prog_data[7:4])][0] == $past(flags_r[FL_C]))
    else $error("rotate left carry path wrong");

endmodule : bsx_core

// *** bsx_prog_mem.sv ***
// Program memory model that answers instruction fetches in the same cycle.
`timescale 1ns/1ps
module bsx_prog_mem
  import bsx_pkg::*;
(
  // Fetch port.
  input  wire logic [PC_W-1:0] prog_addr,
  output logic [15:0]          prog_data
);
  logic [15:0] mem [0:63];
  // Words past the end read as all ones so stray fetches never look like real code.
  assign prog_data = (prog_addr < 22'h000040) ? mem[prog_addr[5:0]] : 16'hffff;
endmodule : bsx_prog_mem

// *** bsx_core_tb.sv ***
// Self-checking bench for the branch, skip and shift execute slice.
`timescale 1ns/1ps
module bsx_core_tb
  import bsx_pkg::*;
;
  logic clk_sys = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic [3:0] avs_byteenable = 4'hf;
  logic [PC_W-1:0] prog_addr;
  logic [15:0] prog_data, stack_addr;
  logic [255:0] io_regs;
  logic stack_we, instr_done;
  logic [7:0] stack_wdata;
  int fail_count = 0, total_checks = 0, sn = 0, n;
  logic pw = 1'b0;
  logic [15:0] exp_sa [0:3] = '{16'h00ff, 16'h00fe, 16'h00fd, 16'h00fc};
  logic [7:0] exp_sd [0:3] = '{8'h0d, 8'h00, 8'h1a, 8'h00};
  // ==========================================================================
  // Clock, design and program memory
  // ==========================================================================
  always #10 clk_sys = ~clk_sys;
  bsx_core dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
    .io_regs(io_regs), .stack_we(stack_we), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .instr_done(instr_done));
  bsx_prog_mem pm (.prog_addr(prog_addr), .prog_data(prog_data));
  // ==========================================================================
  // Checks and bus tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] w);
    avs_address <= a;
    avs_writedata <= w;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    @(posedge clk_sys);
  endtask : bus
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, d);
  endtask : rd_chk
  // Polls the program counter until it reaches the given value, within a bound.
  task automatic run_to(input logic [31:0] e);
    d = 32'h0;
    for (int i = 0; i < 200 && d !== e; i++) bus(1'b0, OFF_PC, 32'h0);
    chk("pc_reached", e, d);
  endtask : run_to
  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Each stack byte must land at the expected address in push order, and a call ends next.
  always @(posedge clk_sys) begin
    if (stack_we === 1'b1) begin
      chk("stack_addr", {16'h0, exp_sa[sn % 4]}, {16'h0, stack_addr});
      chk("stack_data", {24'h0, exp_sd[sn % 4]}, {24'h0, stack_wdata});
      sn++;
    end else if (pw) begin
      chk("call_done", 32'h1, {31'h0, instr_done});
    end
    pw = (stack_we === 1'b1);
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    io_regs = {256{1'b1}};
    io_regs[26] = 1'b0;
    for (int i = 0; i < 64; i++) pm.mem[i] = 16'h0000;
    pm.mem[0] = 16'h0f00;  // Shift r16 left.
    pm.mem[1] = 16'hf008;  // Branch on carry set over word 2.
    pm.mem[2] = 16'hef1f;  // Load all ones into r17, must be skipped.
    pm.mem[3] = 16'h1301;  // Compare r16 with r17 and skip.
    pm.mem[4] = 16'h9409;  // Pointer jump, must be skipped.
    pm.mem[5] = 16'hff01;  // Skip when bit 1 of r16 is set.
    pm.mem[6] = 16'hef0f;  // Load all ones into r16, must be skipped.
    pm.mem[7] = 16'h9409;  // Pointer jump to 0x0a.
    pm.mem[10] = 16'h9517; // Rotate r17 right through carry.
    pm.mem[11] = 16'hf00c; // Branch on N xor V set, not taken.
    pm.mem[12] = 16'hd001; // Offset call to 14.
    pm.mem[14] = 16'h991a; // Skip when I/O bit 3.2 is clear.
    pm.mem[15] = 16'hef0f; // Must be skipped.
    pm.mem[16] = 16'hcfff; // Jump to itself.
    pm.mem[17] = 16'h2311; // Test r17, sets N and S.
    pm.mem[18] = 16'hf00a; // Branch on N set over word 19.
    pm.mem[19] = 16'hef0f; // Must be skipped.
    pm.mem[20] = 16'h1f00; // Rotate r16 left through carry.
    pm.mem[21] = 16'h951a; // Decrement r17.
    pm.mem[22] = 16'hf00c; // Branch on N xor V set over word 23, taken.
    pm.mem[23] = 16'hef1f; // Must be skipped.
    pm.mem[24] = 16'h27ff; // Clear r31, the high byte of the pointer.
    pm.mem[25] = 16'h9509; // Pointer call to 0x1b.
    pm.mem[27] = 16'hffff; // Unknown opcode.
    pm.mem[28] = 16'hcfff; // Jump to itself.
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd_chk("sp_reset", OFF_SP, 32'h000000ff);
    rd_chk("flags_reset", OFF_FLAGS, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    bus(1'b1, 8'h40, 32'h81);
    bus(1'b1, 8'h44, 32'h02);
    bus(1'b1, 8'h78, 32'h0a);
    bus(1'b1, 8'h7c, 32'h00);
    bus(1'b1, OFF_CTRL, 32'h1);
    run_to(32'h10);
    bus(1'b1, OFF_PC, 32'h0);
    bus(1'b1, 8'h40, 32'h55);
    bus(1'b1, OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    rd_chk("pc", OFF_PC, 32'h10);
    rd_chk("r16", 8'h40, 32'h02);
    rd_chk("r17", 8'h44, 32'h81);
    rd_chk("flags", OFF_FLAGS, 32'h0c);
    rd_chk("sp", OFF_SP, 32'hfd);
    rd_chk("status", OFF_STATUS, 32'h200);
    chk("pushes", 32'h2, sn);
    bus(1'b1, OFF_PC, 32'h11);
    bus(1'b1, OFF_FLAGS, 32'h01);
    bus(1'b1, 8'h78, 32'h1b);
    bus(1'b1, 8'h7c, 32'h55);
    bus(1'b1, OFF_CTRL, 32'h1);
    run_to(32'h1c);
    bus(1'b1, OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    rd_chk("pc2", OFF_PC, 32'h1c);
    rd_chk("r16_rol", 8'h40, 32'h05);
    rd_chk("r17_dec", 8'h44, 32'h80);
    rd_chk("r31_clr", 8'h7c, 32'h00);
    rd_chk("flags2", OFF_FLAGS, 32'h02);
    rd_chk("sp2", OFF_SP, 32'hfb);
    rd_chk("status2", OFF_STATUS, 32'h202);
    chk("pushes2", 32'h4, sn);
    bus(1'b1, OFF_CTRL, 32'h2);
    rd_chk("status3", OFF_STATUS, 32'h200);
    results();
  end
endmodule : bsx_core_tb
